// >>> design/mbc_pkg.sv
// Behaviour
// - bias field bits 6-4: 0 reference, 1 reference x1.096, 6 supply; 2-5 and 7 reserved.
// - full-scale field bits 1-0: 0 2.75 V, 1 2.5 V, 2 1.375 V; 3 reserved.
// - channel one bit 7 picks input type: 0 microphone, 1 line.
// - channel one bits 6-5: 0 differential, 1 single-ended, 2 density microphone; 3 reserved.
// - channel one bit 4 picks analog coupling: 0 AC, 1 DC.
// - channel one bits 3-2 impedance: 0 2.5k, 1 10k, 2 20k; 3 reserved.
// - channel one register lives at page 0x00 address 0x3C, resets to zero.
// - channel one bit 0 enables auto gain, using the mode from register 108 bit 3.
package mbc_pkg;

    // =========================================================
    // register map
    localparam logic [7:0] MBC_PAGE_CFG = 8'h00;
    localparam logic [7:0] MBC_ADDR_BIAS = 8'h3B;
    localparam logic [7:0] MBC_ADDR_CHAN_ONE = 8'h3C;
    localparam logic [7:0] MBC_RST_BIAS = 8'h00;
    localparam logic [7:0] MBC_RST_CHAN_ONE = 8'h00;
    localparam logic [7:0] MBC_MASK_BIAS = 8'h73;
    localparam logic [7:0] MBC_MASK_CHAN_ONE = 8'hFD;
    localparam logic [7:0] MBC_RD_UNMAPPED = 8'h00;

    // =========================================================
    // field positions
    localparam int MBC_BIAS_LSB = 4;
    localparam int MBC_FSCALE_LSB = 0;
    localparam int MBC_TYPE_BIT = 7;
    localparam int MBC_SRC_LSB = 5;
    localparam int MBC_DC_BIT = 4;
    localparam int MBC_IMP_LSB = 2;
    localparam int MBC_AGC_BIT = 0;

    // =========================================================
    // field codes
    localparam logic [2:0] MBC_BIAS_VREF = 3'h0;
    localparam logic [2:0] MBC_BIAS_BOOST = 3'h1;
    localparam logic [2:0] MBC_BIAS_SUPPLY = 3'h6;
    localparam logic [1:0] MBC_FS_2V75 = 2'h0;
    localparam logic [1:0] MBC_FS_2V5 = 2'h1;
    localparam logic [1:0] MBC_FS_1V375 = 2'h2;
    localparam logic [1:0] MBC_IMP_2K5 = 2'h0;
    localparam logic [1:0] MBC_IMP_10K = 2'h1;
    localparam logic [1:0] MBC_IMP_20K = 2'h2;

    typedef enum logic [1:0] {
        MBC_SRC_DIFF = 2'h0,
        MBC_SRC_SINGLE = 2'h1,
        MBC_SRC_DENSITY = 2'h2,
        MBC_SRC_RSVD = 2'h3
    } mbc_src_t;

endpackage

// >>> design/mbc_cfg_reg.sv
`timescale 1ns/1ps
`default_nettype none
module mbc_cfg_reg
    import mbc_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hFF
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // write side
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // stored value
    output logic [7:0] value
);

    typedef struct packed {
        logic [7:0] value_reg;
    } mbc_reg_state_t;

    mbc_reg_state_t st_reg;
    mbc_reg_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (wr_en) begin
            // reserved lanes keep their reset value
            st_next.value_reg = (wr_data & WR_MASK) | (RESET_VAL & ~WR_MASK);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{value_reg: RESET_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign value = st_reg.value_reg;

    // =========================================================
    // assertions
    property p_reserved_fixed;
        @(posedge ref_clk) disable iff (!rst_n)
        ((value & ~WR_MASK) == (RESET_VAL & ~WR_MASK));
    endproperty
    a_reserved_fixed: assert property (p_reserved_fixed)
        else $error("reserved bits changed");

    property p_write_lands;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_en |=> ((value & WR_MASK) == ($past(wr_data) & WR_MASK));
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("written field not stored");

endmodule
`default_nettype wire

// >>> design/mbc_bias_chan_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module mbc_bias_chan_cfg
    import mbc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port from the control interface
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    // auto gain mode from the gain-control register bank
    input wire logic agc_mode_sel,
    // microphone bias and full-scale controls
    output logic [2:0] mic_bias_level_select,
    output logic bias_from_reference,
    output logic bias_from_boost,
    output logic bias_from_supply,
    output logic [1:0] converter_fullscale_select,
    output logic fullscale_2v75,
    output logic fullscale_2v5,
    output logic fullscale_1v375,
    // channel one controls
    output logic chan_one_input_type,
    output logic [1:0] chan_one_source_select,
    output logic src_analog_diff,
    output logic src_analog_single,
    output logic src_density_mic,
    output logic chan_one_coupling_select,
    output logic dc_coupling_active,
    output logic [1:0] chan_one_impedance_select,
    output logic imp_2k5,
    output logic imp_10k,
    output logic imp_20k,
    output logic chan_one_auto_gain_enable,
    output logic agc_mode_applied,
    output logic cfg_code_reserved
);

    // =========================================================
    // registers
    logic sel_page;
    logic hit_bias;
    logic hit_chan;
    logic [7:0] bias_val;
    logic [7:0] chan_val;

    assign sel_page = (reg_page == MBC_PAGE_CFG);
    assign hit_bias = sel_page && (reg_addr == MBC_ADDR_BIAS);
    assign hit_chan = sel_page && (reg_addr == MBC_ADDR_CHAN_ONE);

    mbc_cfg_reg #(
        .RESET_VAL(MBC_RST_BIAS),
        .WR_MASK(MBC_MASK_BIAS)
    ) u_bias_reg (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && hit_bias),
        .wr_data(reg_wr_data),
        .value(bias_val)
    );

    mbc_cfg_reg #(
        .RESET_VAL(MBC_RST_CHAN_ONE),
        .WR_MASK(MBC_MASK_CHAN_ONE)
    ) u_chan_reg (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(reg_wr_en && hit_chan),
        .wr_data(reg_wr_data),
        .value(chan_val)
    );

    // =========================================================
    // fields
    logic [2:0] f_bias;
    logic [1:0] f_fs;
    mbc_src_t f_src;
    logic [1:0] f_imp;
    logic f_analog;

    assign f_bias = bias_val[MBC_BIAS_LSB +: 3];
    assign f_fs = bias_val[MBC_FSCALE_LSB +: 2];
    assign f_src = mbc_src_t'(chan_val[MBC_SRC_LSB +: 2]);
    assign f_imp = chan_val[MBC_IMP_LSB +: 2];
    assign f_analog = (f_src == MBC_SRC_DIFF) || (f_src == MBC_SRC_SINGLE);

    // =========================================================
    // state
    typedef struct packed {
        logic [7:0] rd_data;
        logic rd_valid;
        logic b_ref;
        logic b_boost;
        logic b_sup;
        logic fs_a;
        logic fs_b;
        logic fs_c;
        logic s_diff;
        logic s_single;
        logic s_dens;
        logic dc_act;
        logic i_2k5;
        logic i_10k;
        logic i_20k;
        logic agc_mode;
        logic rsvd;
    } mbc_state_t;

    mbc_state_t st_reg;
    mbc_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rd_valid = reg_rd_en;
        if (reg_rd_en) begin
            if (hit_bias) begin
                st_next.rd_data = bias_val;
            end else if (hit_chan) begin
                st_next.rd_data = chan_val;
            end else begin
                st_next.rd_data = MBC_RD_UNMAPPED;
            end
        end
        // reserved codes select no source at all
        st_next.b_ref = (f_bias == MBC_BIAS_VREF);
        st_next.b_boost = (f_bias == MBC_BIAS_BOOST);
        st_next.b_sup = (f_bias == MBC_BIAS_SUPPLY);
        st_next.fs_a = (f_fs == MBC_FS_2V75);
        st_next.fs_b = (f_fs == MBC_FS_2V5);
        st_next.fs_c = (f_fs == MBC_FS_1V375);
        st_next.s_diff = (f_src == MBC_SRC_DIFF);
        st_next.s_single = (f_src == MBC_SRC_SINGLE);
        st_next.s_dens = (f_src == MBC_SRC_DENSITY);
        // coupling and impedance only steer an analog front end
        st_next.dc_act = f_analog && chan_val[MBC_DC_BIT];
        st_next.i_2k5 = f_analog && (f_imp == MBC_IMP_2K5);
        st_next.i_10k = f_analog && (f_imp == MBC_IMP_10K);
        st_next.i_20k = f_analog && (f_imp == MBC_IMP_20K);
        st_next.agc_mode = chan_val[MBC_AGC_BIT] && agc_mode_sel;
        st_next.rsvd = !(st_next.b_ref || st_next.b_boost || st_next.b_sup)
            || (f_fs == 2'h3) || (f_src == MBC_SRC_RSVD) || (f_imp == 2'h3);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{b_ref: 1'b1, fs_a: 1'b1, s_diff: 1'b1, i_2k5: 1'b1, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // outputs
    assign reg_rd_data = st_reg.rd_data;
    assign reg_rd_valid = st_reg.rd_valid;
    assign mic_bias_level_select = f_bias;
    assign bias_from_reference = st_reg.b_ref;
    assign bias_from_boost = st_reg.b_boost;
    assign bias_from_supply = st_reg.b_sup;
    assign converter_fullscale_select = f_fs;
    assign fullscale_2v75 = st_reg.fs_a;
    assign fullscale_2v5 = st_reg.fs_b;
    assign fullscale_1v375 = st_reg.fs_c;
    assign chan_one_input_type = chan_val[MBC_TYPE_BIT];
    assign chan_one_source_select = chan_val[MBC_SRC_LSB +: 2];
    assign src_analog_diff = st_reg.s_diff;
    assign src_analog_single = st_reg.s_single;
    assign src_density_mic = st_reg.s_dens;
    assign chan_one_coupling_select = chan_val[MBC_DC_BIT];
    assign dc_coupling_active = st_reg.dc_act;
    assign chan_one_impedance_select = f_imp;
    assign imp_2k5 = st_reg.i_2k5;
    assign imp_10k = st_reg.i_10k;
    assign imp_20k = st_reg.i_20k;
    assign chan_one_auto_gain_enable = chan_val[MBC_AGC_BIT];
    assign agc_mode_applied = st_reg.agc_mode;
    assign cfg_code_reserved = st_reg.rsvd;

    // =========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_bias_decode;
        ##1 1'b1 |-> (bias_from_boost == ($past(f_bias) == MBC_BIAS_BOOST))
            && (bias_from_supply == ($past(f_bias) == MBC_BIAS_SUPPLY));
    endproperty
    a_bias_decode: assert property (p_bias_decode)
        else $error("bias select does not follow bias field");

    property p_bias_reserved;
        (f_bias inside {3'h2, 3'h3, 3'h4, 3'h5}) |=>
            !bias_from_reference && !bias_from_boost && !bias_from_supply && cfg_code_reserved;
    endproperty
    a_bias_reserved: assert property (p_bias_reserved)
        else $error("reserved bias code selected a source");

    property p_fs_decode;
        (f_fs == MBC_FS_1V375) |=> fullscale_1v375 && !fullscale_2v75 && !fullscale_2v5;
    endproperty
    a_fs_decode: assert property (p_fs_decode)
        else $error("full-scale select wrong");

    property p_type_write;
        (reg_wr_en && hit_chan) |=> (chan_one_input_type == $past(reg_wr_data[7]));
    endproperty
    a_type_write: assert property (p_type_write)
        else $error("input type not taken from write");

    property p_src_onehot;
        ##1 1'b1 |-> (src_density_mic == ($past(f_src) == MBC_SRC_DENSITY))
            && $onehot0({src_analog_diff, src_analog_single, src_density_mic});
    endproperty
    a_src_onehot: assert property (p_src_onehot)
        else $error("source select wrong");

    property p_dc_analog_only;
        (f_src == MBC_SRC_DENSITY) |=> !dc_coupling_active && !imp_2k5 && !imp_10k && !imp_20k;
    endproperty
    a_dc_analog_only: assert property (p_dc_analog_only)
        else $error("analog controls active on density source");

    property p_imp_decode;
        (f_analog && f_imp == MBC_IMP_20K) |=> imp_20k && !imp_10k && !imp_2k5;
    endproperty
    a_imp_decode: assert property (p_imp_decode)
        else $error("impedance select wrong");

    property p_chan_readback;
        (reg_rd_en && hit_chan) |=> reg_rd_valid && (reg_rd_data == $past(chan_val))
            && (reg_rd_data[1] == 1'b0);
    endproperty
    a_chan_readback: assert property (p_chan_readback)
        else $error("channel one readback wrong");

    property p_bias_rsvd_read;
        (reg_rd_en && hit_bias) |=> ((reg_rd_data & ~MBC_MASK_BIAS) == 8'h00);
    endproperty
    a_bias_rsvd_read: assert property (p_bias_rsvd_read)
        else $error("bias reserved bits read nonzero");

    property p_agc_mode;
        ##1 1'b1 |-> (agc_mode_applied == ($past(chan_val[MBC_AGC_BIT]) && $past(agc_mode_sel)));
    endproperty
    a_agc_mode: assert property (p_agc_mode)
        else $error("auto gain mode not applied");

    c_density: cover property ((reg_wr_en && hit_chan && reg_wr_data[6:5] == 2'h2) ##2 src_density_mic);
    c_supply: cover property ((reg_wr_en && hit_bias && reg_wr_data[6:4] == 3'h6) ##2 bias_from_supply);
    c_unmapped: cover property (reg_rd_en && !hit_bias && !hit_chan ##1 reg_rd_valid);

endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import mbc_pkg::*;
;
    // =========================================================
    // stimulus and observed signals
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_page = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_rd_en = 1'b0;
    logic agc_mode_sel = 1'b0;
    logic [7:0] reg_rd_data;
    logic reg_rd_valid;
    logic [2:0] mbl;
    logic [1:0] cfs, src, imp;
    logic b_ref, b_bst, b_sup, f0, f1, f2, ityp, s_d, s_s, s_m, cpl, dca, i0, i1, i2, agc, agm;
    logic rsv;
    logic [7:0] bias_m = 8'h00;
    logic [7:0] chan_m = 8'h00;
    logic [7:0] exp_q[$];
    logic [7:0] exp_e;
    logic [31:0] rs = 32'h0000_3C7A;
    int num_errors = 0;
    int num_checks = 0;

    always #20 ref_clk = ~ref_clk;

    mbc_bias_chan_cfg i_mbc_bias_chan_cfg (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_page(reg_page), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .agc_mode_sel(agc_mode_sel),
        .mic_bias_level_select(mbl), .bias_from_reference(b_ref), .bias_from_boost(b_bst),
        .bias_from_supply(b_sup), .converter_fullscale_select(cfs), .fullscale_2v75(f0),
        .fullscale_2v5(f1), .fullscale_1v375(f2), .chan_one_input_type(ityp),
        .chan_one_source_select(src), .src_analog_diff(s_d), .src_analog_single(s_s),
        .src_density_mic(s_m), .chan_one_coupling_select(cpl), .dc_coupling_active(dca),
        .chan_one_impedance_select(imp), .imp_2k5(i0), .imp_10k(i1), .imp_20k(i2),
        .chan_one_auto_gain_enable(agc), .agc_mode_applied(agm), .cfg_code_reserved(rsv)
    );

    // =========================================================
    // expected decode of the model registers
    wire [2:0] e_bc = bias_m[6:4];
    wire [1:0] e_fs = bias_m[1:0];
    wire [1:0] e_src = chan_m[6:5];
    wire [1:0] e_imp = chan_m[3:2];
    wire e_an = (e_src == 2'h0) || (e_src == 2'h1);
    wire e_rsv = (e_bc != 3'h0 && e_bc != 3'h1 && e_bc != 3'h6) || e_fs == 2'h3
        || e_src == 2'h3 || e_imp == 2'h3;
    wire [26:0] got_w = {mbl, b_ref, b_bst, b_sup, cfs, f0, f1, f2, ityp, src, s_d, s_s, s_m,
        cpl, dca, imp, i0, i1, i2, agc, agm, rsv};
    wire [26:0] exp_w = {e_bc, e_bc == 3'h0, e_bc == 3'h1, e_bc == 3'h6, e_fs, e_fs == 2'h0,
        e_fs == 2'h1, e_fs == 2'h2, chan_m[7], e_src, e_src == 2'h0, e_src == 2'h1,
        e_src == 2'h2, chan_m[4], chan_m[4] && e_an, e_imp, e_an && e_imp == 2'h0,
        e_an && e_imp == 2'h1, e_an && e_imp == 2'h2, chan_m[0], chan_m[0] && agc_mode_sel,
        e_rsv};

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // =========================================================
    // one register access; a read notes its expected byte
    task automatic acc(input logic w, input logic r, input logic [7:0] pg,
        input logic [7:0] ad, input logic [7:0] d, input logic [7:0] e);
        @(posedge ref_clk);
        reg_wr_en <= w;
        reg_rd_en <= r;
        reg_page <= pg;
        reg_addr <= ad;
        reg_wr_data <= d;
        if (r) begin
            exp_q.push_back(e);
        end
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        if (w && pg == 8'h00 && ad == 8'h3B) begin
            bias_m = d & 8'h73;
        end
        if (w && pg == 8'h00 && ad == 8'h3C) begin
            chan_m = d & 8'hFD;
        end
    endtask

    task automatic chk_out();
        repeat (2) @(posedge ref_clk);
        #1;
        num_checks++;
        if (got_w !== exp_w) begin
            num_errors++;
            $display("MISMATCH at %0t: outputs %h expected %h", $time, got_w, exp_w);
        end
    endtask

    // =========================================================
    // read answers are compared against the oldest note
    always @(posedge ref_clk) begin
        if (reg_rd_valid === 1'b1) begin
            num_checks++;
            exp_e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            if (reg_rd_data !== exp_e) begin
                num_errors++;
                $display("MISMATCH at %0t: read %h expected %h", $time, reg_rd_data, exp_e);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("MISMATCH at %0t: run did not finish", $time);
        stop_test();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk_out();
        acc(1'b0, 1'b1, 8'h00, 8'h3C, 8'h00, 8'h00);
        acc(1'b0, 1'b1, 8'h00, 8'h3B, 8'h00, 8'h00);
        for (int i = 0; i < 16; i++) begin
            rs = xs(rs);
            acc(1'b1, 1'b0, 8'h00, 8'h3B,
                {rs[7], 3'(i / 2), rs[3:2], 2'(i % 4)}, 8'h00);
            acc(1'b0, 1'b1, 8'h00, 8'h3B, 8'h00, bias_m);
            chk_out();
        end
        for (int i = 0; i < 16; i++) begin
            rs = xs(rs);
            @(posedge ref_clk);
            agc_mode_sel <= rs[9];
            acc(1'b1, 1'b0, 8'h00, 8'h3C,
                {rs[7], 2'(i % 4), rs[4], 2'(i / 4), rs[1:0]}, 8'h00);
            acc(1'b0, 1'b1, 8'h00, 8'h3C, 8'h00, chan_m);
            chk_out();
        end
        acc(1'b1, 1'b0, 8'h01, 8'h3C, 8'hFF, 8'h00);
        acc(1'b1, 1'b0, 8'h00, 8'h3D, 8'hFF, 8'h00);
        acc(1'b0, 1'b1, 8'h00, 8'h3C, 8'h00, chan_m);
        acc(1'b0, 1'b1, 8'h01, 8'h3C, 8'h00, 8'h00);
        acc(1'b0, 1'b1, 8'h00, 8'h3D, 8'h00, 8'h00);
        acc(1'b1, 1'b1, 8'h00, 8'h3C, 8'hA2, chan_m);
        acc(1'b0, 1'b1, 8'h00, 8'h3C, 8'h00, 8'hA0);
        chk_out();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        bias_m = 8'h00;
        chan_m = 8'h00;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk_out();
        acc(1'b0, 1'b1, 8'h00, 8'h3C, 8'h00, 8'h00);
        for (int k = 0; k < 20 && exp_q.size() != 0; k++) begin
            @(posedge ref_clk);
        end
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("MISMATCH at %0t: read answers missing", $time);
        end
        stop_test();
    end
endmodule
`default_nettype wire
